// ---- rtl/stop_seq_pkg.sv ----
// Package for the motor stop sequencer: modes, timing, bridge type, states and register map
package stop_seq_pkg;

  // Stop option codes
  localparam logic [2:0] MODE_COAST = 3'h0;
  localparam logic [2:0] MODE_RECIRC = 3'h1;
  localparam logic [2:0] MODE_LS_BRAKE = 3'h2;
  localparam logic [2:0] MODE_HS_BRAKE = 3'h3;
  localparam logic [2:0] MODE_SPIN_DOWN = 3'h4;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_THR = 4'h4;
  localparam logic [3:0] OFS_BRK_TIME = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_HS_MOD_BIT = 4;
  localparam int CTRL_STOP_BIT = 8;

  // Reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [7:0] SPIN_THR_RST = 8'h20;
  localparam logic [7:0] BRAKE_THR_RST = 8'h20;
  localparam logic [15:0] BRK_TIME_RST = 16'h0064;
  localparam logic [15:0] RECIRC_RST = 16'h0010;

  // Brake duration unit: 1 us per count at 125 MHz
  localparam int CLK_MHZ = 125;
  localparam int BRK_UNIT_NS = 1000;
  localparam int BRK_UNIT_CYC = (BRK_UNIT_NS * CLK_MHZ) / 1000;

  // Speed ramp: one duty step per this many cycles
  localparam int RAMP_STEP_CYC = 4;

  localparam logic [31:0] UNMAPPED_DATA = 32'h0;

  // Six bridge switch controls, one bit per phase
  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } bridge_s;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_RECIRC,
    ST_RAMP,
    ST_BRAKE,
    ST_PIN_RAMP,
    ST_PIN_BRAKE,
    ST_HIZ
  } state_e;

endpackage

// ---- rtl/motor_stop_sequencer.sv ----
// Motor stop sequencer: stop option handling for a three-phase bridge
//
// Summary of operation
// - Stop behaviour follows 3-bit stop mode select.
// - Mode 000: all six switches off at once.
// - Mode 001: partial turn-off, recirculate, then off.
// - High-side modulation: drop high side, keep low.
// - Low-side modulation: drop low side, keep high.
// - Mode 010: ramp to threshold, low sides on.
// - Mode 011: ramp to threshold, high sides on.
// - Already below threshold: brake immediately.
// - After brake duration: all off, stay off.
// - Brake pin high: ramp, then low sides on; code acts on it from run (ramp) and off (no ramp) only.
// - Pin brake lasts until pin returns low.
// - Mode 100: ramp duty down, then all off.
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module motor_stop_sequencer (
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Motor side
  input wire logic stop_req_i,
  input wire logic brake_pin_i,
  input wire logic [7:0] motor_speed_i,
  input wire logic [7:0] run_duty_i,
  input wire stop_seq_pkg::bridge_s run_bridge_i,
  input wire logic resume_i,
  output stop_seq_pkg::bridge_s bridge_o,
  output logic [7:0] duty_o,
  output logic stop_busy_o,
  output logic hiz_o
);

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic be);
    merge_byte = be ? new_v : old_v;
  endfunction

  function automatic logic [7:0] step_down(input logic [7:0] duty, input logic [7:0] thr);
    step_down = (duty > thr) ? duty - 8'h01 : duty;
  endfunction

  function automatic stop_seq_pkg::bridge_s brake_pattern(input logic [2:0] mode);
    if (mode == stop_seq_pkg::MODE_HS_BRAKE) begin
      brake_pattern = '{hs: 3'h7, ls: 3'h0};
    end else begin
      brake_pattern = '{hs: 3'h0, ls: 3'h7};
    end
  endfunction

  // ==========================================================
  // Registers and Avalon slave
  // ==========================================================
  logic [2:0] mode_q, mode_d;
  logic hs_mod_q, hs_mod_d;
  logic [7:0] spin_thr_q, spin_thr_d;
  logic [7:0] brake_thr_q, brake_thr_d;
  logic [15:0] brk_time_q, brk_time_d;
  logic [15:0] recirc_q, recirc_d;
  logic sw_stop_q, sw_stop_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic wait_q, wait_d;
  logic [1:0] brake_sync_q;
  stop_seq_pkg::state_e state_q, state_d;

  // One-cycle answer: waitrequest is high until the registered acknowledge
  always_comb begin
    mode_d = mode_q;
    hs_mod_d = hs_mod_q;
    spin_thr_d = spin_thr_q;
    brake_thr_d = brake_thr_q;
    brk_time_d = brk_time_q;
    recirc_d = recirc_q;
    sw_stop_d = 1'b0;
    rdata_d = rdata_q;
    ack_d = 1'b0;
    if ((avs_read_i || avs_write_i) && !ack_q) begin
      ack_d = 1'b1;
      rdata_d = stop_seq_pkg::UNMAPPED_DATA;
      if (avs_write_i) begin
        unique case (avs_address_i)
          stop_seq_pkg::OFS_CTRL: begin
            if (avs_byteenable_i[0]) begin
              mode_d = avs_writedata_i[stop_seq_pkg::CTRL_MODE_LSB +: 3];
              hs_mod_d = avs_writedata_i[stop_seq_pkg::CTRL_HS_MOD_BIT];
            end
            if (avs_byteenable_i[1]) begin
              sw_stop_d = avs_writedata_i[stop_seq_pkg::CTRL_STOP_BIT];
            end
          end
          stop_seq_pkg::OFS_THR: begin
            spin_thr_d = merge_byte(spin_thr_q, avs_writedata_i[7:0], avs_byteenable_i[0]);
            brake_thr_d = merge_byte(brake_thr_q, avs_writedata_i[15:8], avs_byteenable_i[1]);
          end
          stop_seq_pkg::OFS_BRK_TIME: begin
            brk_time_d[7:0] = merge_byte(brk_time_q[7:0], avs_writedata_i[7:0],
                                         avs_byteenable_i[0]);
            brk_time_d[15:8] = merge_byte(brk_time_q[15:8], avs_writedata_i[15:8],
                                          avs_byteenable_i[1]);
            recirc_d[7:0] = merge_byte(recirc_q[7:0], avs_writedata_i[23:16],
                                       avs_byteenable_i[2]);
            recirc_d[15:8] = merge_byte(recirc_q[15:8], avs_writedata_i[31:24],
                                        avs_byteenable_i[3]);
          end
          default: begin
          end
        endcase
      end else begin
        unique case (avs_address_i)
          stop_seq_pkg::OFS_CTRL:
            rdata_d = {27'h0, hs_mod_q, 1'b0, mode_q};
          stop_seq_pkg::OFS_THR:
            rdata_d = {16'h0, brake_thr_q, spin_thr_q};
          stop_seq_pkg::OFS_BRK_TIME:
            rdata_d = {recirc_q, brk_time_q};
          stop_seq_pkg::OFS_STATUS:
            rdata_d = {21'h0, duty_o, 3'(state_q)};
          default:
            rdata_d = stop_seq_pkg::UNMAPPED_DATA;
        endcase
      end
    end
    wait_d = !ack_d;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q <= stop_seq_pkg::MODE_RST;
      hs_mod_q <= 1'b1;
      spin_thr_q <= stop_seq_pkg::SPIN_THR_RST;
      brake_thr_q <= stop_seq_pkg::BRAKE_THR_RST;
      brk_time_q <= stop_seq_pkg::BRK_TIME_RST;
      recirc_q <= stop_seq_pkg::RECIRC_RST;
      sw_stop_q <= 1'b0;
      rdata_q <= 32'h0;
      ack_q <= 1'b0;
      wait_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      hs_mod_q <= hs_mod_d;
      spin_thr_q <= spin_thr_d;
      brake_thr_q <= brake_thr_d;
      brk_time_q <= brk_time_d;
      recirc_q <= recirc_d;
      sw_stop_q <= sw_stop_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      wait_q <= wait_d;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;

  // ==========================================================
  // Brake pin synchroniser
  // ==========================================================
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      brake_sync_q <= 2'h0;
    end else begin
      brake_sync_q <= {brake_sync_q[0], brake_pin_i};
    end
  end

  logic brake_pin_s;
  assign brake_pin_s = brake_sync_q[1];

  // ==========================================================
  // Stop sequencer
  // ==========================================================
  stop_seq_pkg::bridge_s bridge_q, bridge_d;
  logic [7:0] duty_q, duty_d;
  logic [31:0] cnt_q, cnt_d;
  logic [1:0] ramp_q, ramp_d;
  logic stop_ev;
  logic hiz_q, hiz_d;
  logic busy_q, busy_d;

  assign stop_ev = stop_req_i || sw_stop_q;

  always_comb begin
    state_d = state_q;
    bridge_d = bridge_q;
    duty_d = duty_q;
    cnt_d = cnt_q;
    ramp_d = ramp_q + 2'h1;
    unique case (state_q)
      stop_seq_pkg::ST_RUN: begin
        bridge_d = run_bridge_i;
        duty_d = run_duty_i;
        if (brake_pin_s) begin
          state_d = stop_seq_pkg::ST_PIN_RAMP;
        end else if (stop_ev) begin
          unique case (mode_q)
            stop_seq_pkg::MODE_RECIRC: begin
              // Keep only the complementary side of the conducting pair
              if (hs_mod_q) begin
                bridge_d = '{hs: 3'h0, ls: run_bridge_i.ls};
              end else begin
                bridge_d = '{hs: run_bridge_i.hs, ls: 3'h0};
              end
              cnt_d = {16'h0, recirc_q};
              state_d = stop_seq_pkg::ST_RECIRC;
            end
            stop_seq_pkg::MODE_LS_BRAKE, stop_seq_pkg::MODE_HS_BRAKE,
            stop_seq_pkg::MODE_SPIN_DOWN: begin
              cnt_d = 32'(brk_time_q) * 32'(stop_seq_pkg::BRK_UNIT_CYC);
              if (mode_q != stop_seq_pkg::MODE_SPIN_DOWN && motor_speed_i <= spin_thr_q) begin
                bridge_d = brake_pattern(mode_q);
                duty_d = 8'h00;
                state_d = stop_seq_pkg::ST_BRAKE;
              end else begin
                state_d = stop_seq_pkg::ST_RAMP;
              end
            end
            default: begin
              bridge_d = '{hs: 3'h0, ls: 3'h0};
              duty_d = 8'h00;
              state_d = stop_seq_pkg::ST_HIZ;
            end
          endcase
        end
      end
      stop_seq_pkg::ST_RECIRC: begin
        if (cnt_q == 32'h0) begin
          bridge_d = '{hs: 3'h0, ls: 3'h0};
          state_d = stop_seq_pkg::ST_HIZ;
        end else begin
          cnt_d = cnt_q - 32'h1;
        end
      end
      stop_seq_pkg::ST_RAMP: begin
        bridge_d = run_bridge_i;
        if (ramp_q == 2'(stop_seq_pkg::RAMP_STEP_CYC - 1)) begin
          duty_d = step_down(duty_q, spin_thr_q);
        end
        if (duty_q <= spin_thr_q) begin
          if (mode_q == stop_seq_pkg::MODE_SPIN_DOWN) begin
            bridge_d = '{hs: 3'h0, ls: 3'h0};
            duty_d = 8'h00;
            state_d = stop_seq_pkg::ST_HIZ;
          end else begin
            bridge_d = brake_pattern(mode_q);
            state_d = stop_seq_pkg::ST_BRAKE;
          end
        end
      end
      stop_seq_pkg::ST_BRAKE: begin
        duty_d = 8'h00;
        bridge_d = brake_pattern(mode_q);
        if (cnt_q == 32'h0) begin
          bridge_d = '{hs: 3'h0, ls: 3'h0};
          state_d = stop_seq_pkg::ST_HIZ;
        end else begin
          cnt_d = cnt_q - 32'h1;
        end
      end
      stop_seq_pkg::ST_PIN_RAMP: begin
        bridge_d = run_bridge_i;
        if (ramp_q == 2'(stop_seq_pkg::RAMP_STEP_CYC - 1)) begin
          duty_d = step_down(duty_q, brake_thr_q);
        end
        if (!brake_pin_s) begin
          state_d = stop_seq_pkg::ST_RUN;
        end else if (duty_q <= brake_thr_q) begin
          state_d = stop_seq_pkg::ST_PIN_BRAKE;
        end
      end
      stop_seq_pkg::ST_PIN_BRAKE: begin
        duty_d = 8'h00;
        bridge_d = '{hs: 3'h0, ls: 3'h7};
        if (!brake_pin_s) begin
          bridge_d = '{hs: 3'h0, ls: 3'h0};
          state_d = stop_seq_pkg::ST_HIZ;
        end
      end
      stop_seq_pkg::ST_HIZ: begin
        // Stop requests are dropped until here; restart needs resume
        bridge_d = '{hs: 3'h0, ls: 3'h0};
        duty_d = 8'h00;
        if (brake_pin_s) begin
          state_d = stop_seq_pkg::ST_PIN_BRAKE;
        end else if (resume_i) begin
          state_d = stop_seq_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = stop_seq_pkg::ST_HIZ;
      end
    endcase
    hiz_d = (state_d == stop_seq_pkg::ST_HIZ);
    busy_d = (state_d != stop_seq_pkg::ST_RUN) && (state_d != stop_seq_pkg::ST_HIZ);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= stop_seq_pkg::ST_HIZ;
      bridge_q <= '{hs: 3'h0, ls: 3'h0};
      duty_q <= 8'h00;
      cnt_q <= 32'h0;
      ramp_q <= 2'h0;
      hiz_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bridge_q <= bridge_d;
      duty_q <= duty_d;
      cnt_q <= cnt_d;
      ramp_q <= ramp_d;
      hiz_q <= hiz_d;
      busy_q <= busy_d;
    end
  end

  assign bridge_o = bridge_q;
  assign duty_o = duty_q;
  assign hiz_o = hiz_q;
  assign stop_busy_o = busy_q;

endmodule

// ---- testbench/motor_model.sv ----
// Behavioural motor seen through the half-bridges
`timescale 1ns/1ps
module motor_model (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] duty_i,
  input wire stop_seq_pkg::bridge_s bridge_i,
  output logic [7:0] speed_o
);
  // ====
  // Speed follows duty while driven, decays slowly when floating
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) speed_o <= 8'h00;
    else if (bridge_i != 6'h00) speed_o <= duty_i;
    else if (speed_o != 8'h00) speed_o <= speed_o - 8'h01;
  end
endmodule

// ---- testbench/motor_stop_monitor.sv ----
// Checker for the stop sequencer ports
`timescale 1ns/1ps
module motor_stop_monitor (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic avs_waitrequest_o,
  input wire logic stop_req_i,
  input wire logic brake_pin_i,
  input wire logic [7:0] motor_speed_i,
  input wire stop_seq_pkg::bridge_s run_bridge_i,
  input wire stop_seq_pkg::bridge_s bridge_o,
  input wire logic [7:0] duty_o,
  input wire logic stop_busy_o,
  input wire logic hiz_o
);
  logic [2:0] mode_q;
  logic hs_q;
  logic [7:0] thr_q;
  logic [15:0] brk_q;
  logic [31:0] cnt_q;
  logic run;
  assign run = !stop_busy_o && !hiz_o && stop_req_i;
  // ====
  // Shadow of configuration, bytes assumed whole
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q <= stop_seq_pkg::MODE_RST;
      hs_q <= 1'b1;
      thr_q <= stop_seq_pkg::SPIN_THR_RST;
      brk_q <= stop_seq_pkg::BRK_TIME_RST;
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= (stop_busy_o && bridge_o == 6'h38) ? cnt_q + 32'h1 : 32'h0;
      if (avs_write_i && !avs_waitrequest_o) begin
        if (avs_address_i == stop_seq_pkg::OFS_CTRL) begin
          mode_q <= avs_writedata_i[2:0];
          hs_q <= avs_writedata_i[4];
        end
        if (avs_address_i == stop_seq_pkg::OFS_THR) thr_q <= avs_writedata_i[7:0];
        if (avs_address_i == stop_seq_pkg::OFS_BRK_TIME) brk_q <= avs_writedata_i[15:0];
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_coast_off: assert property (run && (mode_q == 3'h0 || mode_q > 3'h4)
    |=> hiz_o && bridge_o == 6'h00) else $error("coast stop left a switch on");
  a_recirc_low: assert property (run && mode_q == 3'h1 && hs_q
    |=> bridge_o == {3'h0, $past(run_bridge_i.ls)}) else $error("low recirculation wrong");
  a_recirc_high: assert property (run && mode_q == 3'h1 && !hs_q
    |=> bridge_o == {$past(run_bridge_i.hs), 3'h0}) else $error("high recirculation wrong");
  a_brake_skip: assert property (run && mode_q == 3'h2 && motor_speed_i <= thr_q
    |=> bridge_o == 6'h07) else $error("brake not entered at once");
  a_brake_end: assert property (stop_busy_o && bridge_o == 6'h38 ##1 bridge_o != 6'h38
    |-> hiz_o && bridge_o == 6'h00) else $error("brake did not end in off state");
  a_brake_len: assert property (cnt_q <= 32'(brk_q) * 32'(stop_seq_pkg::BRK_UNIT_CYC) + 32'h1)
    else $error("high side brake too long");
  a_pin_hold: assert property (brake_pin_i [*4] ##0 bridge_o == 6'h07
    |=> bridge_o == 6'h07) else $error("pin brake released early");
  a_duty_down: assert property (stop_busy_o && $past(stop_busy_o)
    |-> duty_o <= $past(duty_o)) else $error("duty rose during stop");
  a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus answer late");
  c_coast: cover property (run && mode_q == 3'h0);
  c_hs_brake: cover property (stop_busy_o && bridge_o == 6'h38);
  c_pin: cover property (brake_pin_i && bridge_o == 6'h07);
endmodule
bind motor_stop_sequencer motor_stop_monitor u_mon (.*);

// ---- testbench/tb_motor_stop_sequencer.sv ----
// Self-checking bench for the motor stop sequencer
`timescale 1ns/1ps
module tb_motor_stop_sequencer;
  logic clk_i, arst_n_i, avs_read_i, avs_write_i, stop_req_i, brake_pin_i, resume_i;
  logic avs_waitrequest_o, stop_busy_o, hiz_o;
  logic [3:0] avs_address_i;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [7:0] motor_speed_i, run_duty_i, duty_o;
  stop_seq_pkg::bridge_s run_bridge_i, bridge_o;
  int miscompares = 0, tests_run = 0, cyc = 0;
  motor_stop_sequencer u_dut (.*);
  motor_model u_motor (.clk_i(clk_i), .arst_n_i(arst_n_i), .duty_i(duty_o),
    .bridge_i(bridge_o), .speed_o(motor_speed_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ====
  // Tasks
  task automatic test_done;
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic go(input logic [2:0] m, input logic hs, input logic [7:0] dty, input logic s);
    acc(1'b1, stop_seq_pkg::OFS_CTRL, {27'h0, hs, 1'b0, m});
    run_duty_i <= dty;
    resume_i <= 1'b1;
    @(posedge clk_i);
    resume_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    stop_req_i <= s;
    @(posedge clk_i);
    stop_req_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic off(input int n);
    for (int i = 0; i < n && hiz_o !== 1'b1; i++) @(posedge clk_i);
    chk("off", 32'h40, {25'h0, hiz_o, bridge_o});
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done;
    end
  end
  // ====
  // Sequence
  initial begin
    {arst_n_i, avs_read_i, avs_write_i, stop_req_i, brake_pin_i, resume_i} = 6'h00;
    {avs_address_i, avs_writedata_i, run_duty_i} = 44'h0;
    run_bridge_i = 6'h21;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    chk("hiz_rst", 32'h40, {25'h0, hiz_o, bridge_o});
    acc(1'b0, stop_seq_pkg::OFS_THR, 32'h0);
    chk("thr_rst", 32'h2020, rd);
    acc(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
    acc(1'b1, stop_seq_pkg::OFS_BRK_TIME, 32'h0005_0001);
    acc(1'b1, stop_seq_pkg::OFS_THR, 32'h0000_2020);
    for (int m = 0; m < 8; m++) if (m == 0 || m > 4) begin
      go(m[2:0], 1'b1, 8'h28, 1'b1);
      chk("coast", 32'h40, {25'h0, hiz_o, bridge_o});
    end
    for (int h = 0; h < 2; h++) begin
      go(3'h1, h[0], 8'h28, 1'b1);
      chk("recirc", h ? 32'h01 : 32'h20, {26'h0, bridge_o});
      repeat (3) @(posedge clk_i);
      chk("recirc_hold", h ? 32'h01 : 32'h20, {26'h0, bridge_o});
      off(20);
    end
    go(3'h2, 1'b1, 8'h10, 1'b1);
    chk("ls_brake", 32'h07, {26'h0, bridge_o});
    stop_req_i <= 1'b1;
    @(posedge clk_i);
    stop_req_i <= 1'b0;
    repeat (100) @(posedge clk_i);
    chk("ls_hold", 32'h07, {26'h0, bridge_o});
    off(300);
    go(3'h3, 1'b1, 8'h28, 1'b1);
    chk("hs_ramp", 32'h1, {31'h0, bridge_o != 6'h38});
    for (int i = 0; i < 100 && bridge_o !== 6'h38; i++) @(posedge clk_i);
    chk("hs_brake", 32'h1, {31'h0, bridge_o == 6'h38 && duty_o <= 8'h20});
    repeat (120) @(posedge clk_i);
    chk("hs_hold", 32'h38, {26'h0, bridge_o});
    off(300);
    go(3'h4, 1'b1, 8'h28, 1'b1);
    chk("spin_busy", 32'h1, {31'h0, stop_busy_o});
    off(100);
    go(3'h0, 1'b1, 8'h28, 1'b0);
    acc(1'b1, stop_seq_pkg::OFS_CTRL, 32'h0000_0110);
    chk("sw_stop", 32'h40, {25'h0, hiz_o, bridge_o});
    go(3'h0, 1'b1, 8'h28, 1'b0);
    brake_pin_i <= 1'b1;
    for (int i = 0; i < 100 && bridge_o !== 6'h07; i++) @(posedge clk_i);
    repeat (300) @(posedge clk_i);
    chk("pin_brake", 32'h07, {26'h0, bridge_o});
    brake_pin_i <= 1'b0;
    off(20);
    test_done;
  end
endmodule
